// file: verilog/fcp_defs.svh
// register offsets, reset values and timing counts for the fault code block
// assumes a 250 MHz system clock
`ifndef FCP_DEFS_SVH
`define FCP_DEFS_SVH
`define FCP_OFF_CODE_SEL   8'h00
`define FCP_OFF_OPL_EN     8'h04
`define FCP_OFF_IPL_EN     8'h08
`define FCP_OFF_PFS_SEL    8'h0C
`define FCP_OFF_UGR_SEL    8'h10
`define FCP_OFF_STATUS     8'h14
`define FCP_OFF_IRQ_STAT   8'h18
`define FCP_OFF_IRQ_MASK   8'h1C
`define FCP_RST_CODE_SEL   8'h00
`define FCP_RST_OPL_EN     8'h01
`define FCP_RST_IPL_EN     8'h00
`define FCP_RST_PFS_SEL    8'h00
`define FCP_RST_UGR_SEL    8'h00
`define FCP_CLK_MHZ        250
`define FCP_IPL_TIME_MS    1000
`define FCP_IPL_CYCLES     (`FCP_IPL_TIME_MS * 1000 * `FCP_CLK_MHZ)
`define FCP_CODE_NONE      4'h0
`define FCP_CODE_OV        4'h4
`define FCP_CODE_OPT       4'hE
`define FCP_CODE_OTHER     4'hF
`define FCP_RESP_OKAY      2'b00
`define FCP_RESP_SLVERR    2'b10
`endif

// file: verilog/fcp_pkg.sv
// types for the fault code block
// assumes fcp_defs.svh for numeric constants
package fcp_pkg;
  typedef struct packed {
    logic oc_accel;
    logic oc_const;
    logic oc_decel;
    logic overvoltage;
    logic motor_thermal;
    logic drive_thermal;
    logic momentary_power;
    logic undervoltage;
    logic heatsink;
    logic brake_transistor;
    logic ground;
    logic external_thermal;
    logic stall;
    logic option_a;
    logic option_b;
    logic other;
  } fcp_faults_t;

  typedef struct packed {
    logic [3:0] data;
    logic [3:0] oe_n;
  } fcp_term_t;

  typedef enum logic [1:0] {
    FCP_IDLE  = 2'b00,
    FCP_RESP  = 2'b01
  } fcp_bus_t;
endpackage : fcp_pkg

// file: verilog/fcp_top.sv
// fault code terminal output and phase loss trip logic
// assumes synchronous inputs, one 250 MHz clock, AXI4-Lite master
`include "fcp_defs.svh"
module fcp_top #(
  parameter int unsigned IPL_CYCLES = `FCP_IPL_CYCLES
) (
  input  wire logic               aclk,
  input  wire logic               aresetn,
  input  wire logic               clk_en,
  input  wire logic [7:0]         s_axi_awaddr,
  input  wire logic               s_axi_awvalid,
  output logic                    s_axi_awready,
  input  wire logic [31:0]        s_axi_wdata,
  input  wire logic [3:0]         s_axi_wstrb,
  input  wire logic               s_axi_wvalid,
  output logic                    s_axi_wready,
  output logic [1:0]              s_axi_bresp,
  output logic                    s_axi_bvalid,
  input  wire logic               s_axi_bready,
  input  wire logic [7:0]         s_axi_araddr,
  input  wire logic               s_axi_arvalid,
  output logic                    s_axi_arready,
  output logic [31:0]             s_axi_rdata,
  output logic [1:0]              s_axi_rresp,
  output logic                    s_axi_rvalid,
  input  wire logic               s_axi_rready,
  input  wire fcp_pkg::fcp_faults_t faults,
  input  wire logic               output_phase_lost,
  input  wire logic               input_phase_one_lost,
  input  wire logic               input_phase_two_lost,
  input  wire logic               input_phase_three_lost,
  input  wire logic               fault_reset,
  input  wire logic [3:0]         output_terminal_assignments,
  output logic [3:0]              term_out,
  output logic [3:0]              term_oe_n,
  output logic                    output_phase_loss_trip,
  output logic                    input_phase_loss_trip,
  output logic                    power_fail_decel,
  output logic                    output_shutoff,
  output logic                    irq
);
  logic [7:0]  code_sel_reg, opl_en_reg, ipl_en_reg, pfs_sel_reg, ugr_sel_reg;
  logic [3:0]  irq_stat_reg, irq_mask_reg;
  logic [3:0]  code_reg, code_next;
  logic        fault_reg;
  logic [31:0] ipl_cnt_reg;
  logic        aw_got_reg, w_got_reg;
  logic [7:0]  aw_addr_reg;
  logic [31:0] w_data_reg;
  logic [3:0]  w_strb_reg;

  // fault encoding, first listed fault wins
  always_comb begin
    code_next = `FCP_CODE_NONE;
    if (faults.oc_accel) code_next = 4'h1;
    else if (faults.oc_const) code_next = 4'h2;
    else if (faults.oc_decel) code_next = 4'h3;
    else if (faults.overvoltage) code_next = `FCP_CODE_OV;
    else if (faults.motor_thermal) code_next = 4'h5;
    else if (faults.drive_thermal) code_next = 4'h6;
    else if (faults.momentary_power) code_next = 4'h7;
    else if (faults.undervoltage) code_next = 4'h8;
    else if (faults.heatsink) code_next = 4'h9;
    else if (faults.brake_transistor) code_next = 4'hA;
    else if (faults.ground) code_next = 4'hB;
    else if (faults.external_thermal) code_next = 4'hC;
    else if (faults.stall) code_next = 4'hD;
    else if (faults.option_a || faults.option_b) code_next = `FCP_CODE_OPT;
    else if (faults.other || input_phase_loss_trip || output_phase_loss_trip)
      code_next = `FCP_CODE_OTHER;
  end

  // phase loss
  wire ipl_cond   = input_phase_one_lost | input_phase_two_lost | input_phase_three_lost;
  wire ipl_double = input_phase_one_lost & input_phase_two_lost;
  wire ipl_on     = ipl_en_reg == 8'h01;
  wire ipl_done   = ipl_cnt_reg >= (IPL_CYCLES - 1);
  wire ipl_fire   = ipl_on & ipl_cond & ipl_done & ~ipl_double & (pfs_sel_reg == 8'h00);
  wire opl_fire   = (opl_en_reg != 8'h00) & output_phase_lost;
  wire new_trip   = (code_next != `FCP_CODE_NONE) & ~fault_reg;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ipl_cnt_reg <= 32'h0;
      input_phase_loss_trip <= 1'b0;
      output_phase_loss_trip <= 1'b0;
      power_fail_decel <= 1'b0;
      output_shutoff <= 1'b0;
    end else if (clk_en) begin
      if (!ipl_cond || !ipl_on) ipl_cnt_reg <= 32'h0;
      else if (!ipl_done) ipl_cnt_reg <= ipl_cnt_reg + 32'h1;
      if (fault_reset) begin
        input_phase_loss_trip <= 1'b0;
        output_phase_loss_trip <= 1'b0;
      end else begin
        if (ipl_fire) input_phase_loss_trip <= 1'b1;
        if (opl_fire) output_phase_loss_trip <= 1'b1;
      end
      power_fail_decel <= ipl_on & ipl_cond & (pfs_sel_reg != 8'h00);
      output_shutoff <= ipl_double | opl_fire;
    end
  end

  // code latch held until fault reset
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      code_reg <= `FCP_CODE_NONE;
      fault_reg <= 1'b0;
    end else if (clk_en) begin
      if (fault_reset) begin
        code_reg <= `FCP_CODE_NONE;
        fault_reg <= 1'b0;
      end else if (new_trip) begin
        code_reg <= code_next;
        fault_reg <= 1'b1;
      end
    end
  end

  // terminal drive, 1 turns transistor on (oe_n low)
  wire [3:0] term_val = (code_sel_reg == 8'h01) ? code_reg :
                        (code_sel_reg == 8'h02 && fault_reg) ? code_reg :
                        output_terminal_assignments;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      term_out <= 4'h0;
      term_oe_n <= 4'hF;
    end else if (clk_en) begin
      term_out <= 4'h0;
      term_oe_n <= ~term_val;
    end
  end

  // axi4-lite write path
  wire wr_fire = aw_got_reg & w_got_reg & ~s_axi_bvalid;
  wire wr_lock = ugr_sel_reg != 8'h00;
  wire wr_sel  = (aw_addr_reg == `FCP_OFF_CODE_SEL) | (aw_addr_reg == `FCP_OFF_OPL_EN) |
                 (aw_addr_reg == `FCP_OFF_IPL_EN);
  wire wr_ok   = (aw_addr_reg == `FCP_OFF_PFS_SEL) | (aw_addr_reg == `FCP_OFF_UGR_SEL) |
                 (aw_addr_reg == `FCP_OFF_IRQ_MASK) | (wr_sel & ~wr_lock);
  wire wr_lane = w_strb_reg[0];
  wire [7:0] wb = w_data_reg[7:0];

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_got_reg <= 1'b0;
      w_got_reg <= 1'b0;
      aw_addr_reg <= 8'h00;
      w_data_reg <= 32'h0;
      w_strb_reg <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `FCP_RESP_OKAY;
      code_sel_reg <= `FCP_RST_CODE_SEL;
      opl_en_reg <= `FCP_RST_OPL_EN;
      ipl_en_reg <= `FCP_RST_IPL_EN;
      pfs_sel_reg <= `FCP_RST_PFS_SEL;
      ugr_sel_reg <= `FCP_RST_UGR_SEL;
      irq_mask_reg <= 4'h0;
    end else if (clk_en) begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_got_reg <= 1'b1;
        aw_addr_reg <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_got_reg <= 1'b1;
        w_data_reg <= s_axi_wdata;
        w_strb_reg <= s_axi_wstrb;
      end
      if (wr_fire) begin
        aw_got_reg <= 1'b0;
        w_got_reg <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_ok ? `FCP_RESP_OKAY : `FCP_RESP_SLVERR;
        if (wr_ok && wr_lane) begin
          case (aw_addr_reg)
            `FCP_OFF_CODE_SEL: code_sel_reg <= wb;
            `FCP_OFF_OPL_EN:   opl_en_reg <= wb;
            `FCP_OFF_IPL_EN:   ipl_en_reg <= wb;
            `FCP_OFF_PFS_SEL:  pfs_sel_reg <= wb;
            `FCP_OFF_UGR_SEL:  ugr_sel_reg <= wb;
            `FCP_OFF_IRQ_MASK: irq_mask_reg <= wb[3:0];
            default: ;
          endcase
        end
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end
  assign s_axi_awready = ~aw_got_reg & ~s_axi_bvalid;
  assign s_axi_wready  = ~w_got_reg & ~s_axi_bvalid;

  // axi4-lite read path and interrupt status
  wire [31:0] status_word = {20'h0, ipl_cond, output_phase_loss_trip, input_phase_loss_trip,
                             fault_reg, 4'h0, code_reg};
  wire        rd_take = s_axi_arvalid & s_axi_arready;
  wire        rd_stat = rd_take & (s_axi_araddr == `FCP_OFF_IRQ_STAT);
  wire [3:0]  irq_ev  = {opl_fire & ~output_phase_loss_trip, ipl_fire & ~input_phase_loss_trip,
                         ipl_double, new_trip};
  logic [31:0] rd_word;
  always_comb begin
    case (s_axi_araddr)
      `FCP_OFF_CODE_SEL: rd_word = {24'h0, code_sel_reg};
      `FCP_OFF_OPL_EN:   rd_word = {24'h0, opl_en_reg};
      `FCP_OFF_IPL_EN:   rd_word = {24'h0, ipl_en_reg};
      `FCP_OFF_PFS_SEL:  rd_word = {24'h0, pfs_sel_reg};
      `FCP_OFF_UGR_SEL:  rd_word = {24'h0, ugr_sel_reg};
      `FCP_OFF_STATUS:   rd_word = status_word;
      `FCP_OFF_IRQ_STAT: rd_word = {28'h0, irq_stat_reg};
      `FCP_OFF_IRQ_MASK: rd_word = {28'h0, irq_mask_reg};
      default:           rd_word = 32'h0;
    endcase
  end
  wire rd_hit = (s_axi_araddr[1:0] == 2'b00) && (s_axi_araddr <= `FCP_OFF_IRQ_MASK);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0;
      s_axi_rresp <= `FCP_RESP_OKAY;
      irq_stat_reg <= 4'h0;
      irq <= 1'b0;
    end else if (clk_en) begin
      if (rd_take) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rd_word;
        s_axi_rresp <= rd_hit ? `FCP_RESP_OKAY : `FCP_RESP_SLVERR;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
      irq_stat_reg <= (rd_stat ? 4'h0 : irq_stat_reg) | irq_ev;
      irq <= |(((rd_stat ? 4'h0 : irq_stat_reg) | irq_ev) & irq_mask_reg);
    end
  end
  assign s_axi_arready = ~s_axi_rvalid;

  // assertions
  a_sel0_no_code: assert property (@(posedge aclk) disable iff (!aresetn)
    clk_en && code_sel_reg == 8'h00 |=> term_oe_n == ~$past(output_terminal_assignments))
    else $error("select 0 drove fault code");
  a_sel1_code: assert property (@(posedge aclk) disable iff (!aresetn)
    clk_en && code_sel_reg == 8'h01 |=> term_oe_n == ~$past(code_reg))
    else $error("select 1 code missing");
  a_sel2_fault: assert property (@(posedge aclk) disable iff (!aresetn)
    clk_en && code_sel_reg == 8'h02 && fault_reg |=> term_oe_n == ~$past(code_reg))
    else $error("select 2 code missing in fault");
  a_oc_encode: assert property (@(posedge aclk) disable iff (!aresetn)
    clk_en && faults.oc_decel && !faults.oc_accel && !faults.oc_const && !fault_reg
    && !fault_reset |=> code_reg == 4'h3)
    else $error("overcurrent decel code wrong");
  a_other_code: assert property (@(posedge aclk) disable iff (!aresetn)
    clk_en && faults == 16'h0001 && !fault_reg && !fault_reset |=> code_reg == 4'hF)
    else $error("unlisted fault not code F");
  a_opl_off: assert property (@(posedge aclk) disable iff (!aresetn)
    opl_en_reg == 8'h00 && !output_phase_loss_trip |=> !output_phase_loss_trip)
    else $error("output phase trip while disabled");
  a_ipl_early: assert property (@(posedge aclk) disable iff (!aresetn)
    ipl_cnt_reg < (IPL_CYCLES - 1) && !input_phase_loss_trip |=> !input_phase_loss_trip)
    else $error("input trip before persistence");
  a_pfs_block: assert property (@(posedge aclk) disable iff (!aresetn)
    pfs_sel_reg != 8'h00 && !input_phase_loss_trip |=> !input_phase_loss_trip)
    else $error("input trip despite power failure stop");
  a_ipl_clear: assert property (@(posedge aclk) disable iff (!aresetn)
    clk_en && !ipl_cond |=> ipl_cnt_reg == 32'h0)
    else $error("persistence counter not cleared");
  a_wr_lock: assert property (@(posedge aclk) disable iff (!aresetn)
    clk_en && wr_lock && wr_fire |=> code_sel_reg == $past(code_sel_reg))
    else $error("write taken while locked");
  a_code_hold: assert property (@(posedge aclk) disable iff (!aresetn)
    fault_reg && !fault_reset |=> code_reg == $past(code_reg))
    else $error("fault code changed before reset");
  c_trip: cover property (@(posedge aclk) disable iff (!aresetn) new_trip && clk_en);
  c_ipl: cover property (@(posedge aclk) disable iff (!aresetn) $rose(input_phase_loss_trip));
  c_irq: cover property (@(posedge aclk) disable iff (!aresetn) $rose(irq));
endmodule : fcp_top

// file: verification/fcp_plc_model.sv
// controller model that samples the four fault code terminals
// assumes open-collector terminals with pull-ups on the controller side
module fcp_plc_model (
  input  wire logic       aclk,
  input  wire logic [3:0] term_out,
  input  wire logic [3:0] term_oe_n,
  output logic [3:0]      code
);
  timeunit 1ns;
  timeprecision 1ps;
  wire logic [3:0] line_lvl;
  // released terminal floats to the pull-up, conducting one pulls low
  assign line_lvl = term_oe_n | term_out;
  // a conducting transistor reads as a one bit of the code
  always_ff @(posedge aclk) begin
    code <= ~line_lvl;
  end
endmodule : fcp_plc_model

// file: verification/fcp_top_bench.sv
// directed bench for the fault code block over its register bus
// assumes fcp_top with a short input loss count and the controller model
`include "fcp_defs.svh"
module fcp_top_bench;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int unsigned IPL = 20;
  localparam logic [63:0] CODES = 64'h123456789ABCDEEF;
  logic aclk, aresetn, clk_en, fault_reset, opl, ip1, ip2, ip3, irq;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
  logic s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0] s_axi_wstrb, asg, term_out, term_oe_n, code;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic opl_trip, ipl_trip, decel, shutoff;
  fcp_pkg::fcp_faults_t faults;
  int fail_count, n_checks;

  fcp_top #(.IPL_CYCLES(IPL)) dut (
    .aclk, .aresetn, .clk_en, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .faults,
    .output_phase_lost(opl), .input_phase_one_lost(ip1), .input_phase_two_lost(ip2),
    .input_phase_three_lost(ip3), .fault_reset, .output_terminal_assignments(asg),
    .term_out, .term_oe_n, .output_phase_loss_trip(opl_trip),
    .input_phase_loss_trip(ipl_trip), .power_fail_decel(decel),
    .output_shutoff(shutoff), .irq);

  fcp_plc_model plc (.aclk(aclk), .term_out(term_out), .term_oe_n(term_oe_n), .code(code));

  initial begin
    aclk = 1'b0;
    forever #2 aclk = ~aclk;
  end

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : wrap_up

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      $display("wrong value %s expected %h seen %h", nm, e, g);
      fail_count++;
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    logic aw, w, b;
    logic [1:0] rs;
    b = 1'b0;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!b) begin
      @(negedge aclk);
      aw = s_axi_awvalid && s_axi_awready;
      w = s_axi_wvalid && s_axi_wready;
      b = s_axi_bvalid && s_axi_bready;
      rs = s_axi_bresp;
      @(posedge aclk);
      if (aw) s_axi_awvalid <= 1'b0;
      if (w) s_axi_wvalid <= 1'b0;
    end
    s_axi_bready <= 1'b0;
    chk("bresp", er, rs);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] m, e, input logic [1:0] er);
    logic ah, rh;
    logic [31:0] d;
    logic [1:0] rs;
    rh = 1'b0;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    while (!rh) begin
      @(negedge aclk);
      ah = s_axi_arvalid && s_axi_arready;
      rh = s_axi_rvalid && s_axi_rready;
      d = s_axi_rdata;
      rs = s_axi_rresp;
      @(posedge aclk);
      if (ah) s_axi_arvalid <= 1'b0;
    end
    s_axi_rready <= 1'b0;
    chk("rresp", er, rs);
    chk("rdata", e, d & m);
  endtask : rd

  task automatic see(input string nm, ref logic s, input logic e, input int n);
    for (int i = 0; i < n && s !== e; i++) @(negedge aclk);
    chk(nm, e, s);
  endtask : see

  task automatic keep(input string nm, ref logic s, input logic e, input int n);
    for (int i = 0; i < n && s === e; i++) @(negedge aclk);
    chk(nm, e, s);
  endtask : keep

  task automatic see_code(input logic [3:0] e);
    for (int i = 0; i < 12 && code !== e; i++) @(negedge aclk);
    chk("code", e, code);
  endtask : see_code

  task automatic clr();
    @(posedge aclk);
    faults <= '0;
    {opl, ip1, ip2, ip3} <= 4'h0;
    fault_reset <= 1'b1;
    @(posedge aclk);
    fault_reset <= 1'b0;
  endtask : clr

  initial begin
    {aresetn, fault_reset, opl, ip1, ip2, ip3} = 6'h00;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 48'h0;
    {clk_en, s_axi_wstrb, asg} = 9'h1F5;
    faults = '0;
    fail_count = 0;
    n_checks = 0;
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    rd(8'h00, 32'hFF, 32'h00, `FCP_RESP_OKAY);
    rd(8'h04, 32'hFF, 32'h01, `FCP_RESP_OKAY);
    rd(8'h08, 32'hFF, 32'h00, `FCP_RESP_OKAY);
    rd(8'h40, 32'hFFFFFFFF, 32'h0, `FCP_RESP_SLVERR);
    faults <= fcp_pkg::fcp_faults_t'(16'h2000);
    repeat (8) @(negedge aclk);
    chk("code", 4'h5, code);
    wr(8'h00, 32'h2, `FCP_RESP_OKAY);
    see_code(4'h3);
    clr();
    see_code(4'h5);
    wr(8'h00, 32'h1, `FCP_RESP_OKAY);
    see_code(4'h0);
    for (int i = 0; i < 16; i++) begin
      @(posedge aclk);
      faults <= fcp_pkg::fcp_faults_t'(16'h8000 >> i);
      see_code(CODES[60-4*i +: 4]);
      @(posedge aclk);
      faults <= '0;
      repeat (4) @(negedge aclk);
      chk("held", CODES[60-4*i +: 4], code);
      clr();
      see_code(4'h0);
    end
    wr(8'h10, 32'h1, `FCP_RESP_OKAY);
    wr(8'h00, 32'h0, `FCP_RESP_SLVERR);
    rd(8'h00, 32'hFF, 32'h01, `FCP_RESP_OKAY);
    wr(8'h10, 32'h0, `FCP_RESP_OKAY);
    wr(8'h1C, 32'h8, `FCP_RESP_OKAY);
    opl <= 1'b1;
    see("opl trip", opl_trip, 1'b1, 10);
    see_code(4'hF);
    rd(8'h14, 32'h70F, 32'h50F, `FCP_RESP_OKAY);
    see("irq", irq, 1'b1, 10);
    clr();
    see("opl cleared", opl_trip, 1'b0, 10);
    chk("irq sticky", 1'b1, irq);
    rd(8'h18, 32'h8, 32'h8, `FCP_RESP_OKAY);
    see("irq cleared", irq, 1'b0, 5);
    wr(8'h1C, 32'h0, `FCP_RESP_OKAY);
    opl <= 1'b1;
    keep("irq masked", irq, 1'b0, 10);
    clr();
    rd(8'h18, 32'h8, 32'h8, `FCP_RESP_OKAY);
    wr(8'h04, 32'h0, `FCP_RESP_OKAY);
    opl <= 1'b1;
    keep("opl off", opl_trip, 1'b0, 10);
    clr();
    wr(8'h04, 32'h1, `FCP_RESP_OKAY);
    wr(8'h08, 32'h1, `FCP_RESP_OKAY);
    ip3 <= 1'b1;
    repeat (IPL - 2) @(posedge aclk);
    ip3 <= 1'b0;
    @(posedge aclk);
    ip3 <= 1'b1;
    repeat (IPL - 2) @(posedge aclk);
    chk("ipl early", 1'b0, ipl_trip);
    see("ipl trip", ipl_trip, 1'b1, 10);
    clr();
    wr(8'h0C, 32'h1, `FCP_RESP_OKAY);
    ip2 <= 1'b1;
    see("decel", decel, 1'b1, 30);
    keep("ipl pfs", ipl_trip, 1'b0, 30);
    clr();
    wr(8'h0C, 32'h0, `FCP_RESP_OKAY);
    {ip1, ip2} <= 2'b11;
    see("shutoff", shutoff, 1'b1, 30);
    keep("ipl both", ipl_trip, 1'b0, 30);
    clr();
    wrap_up();
  end

  initial begin
    #200000;
    fail_count++;
    wrap_up();
  end
endmodule : fcp_top_bench
